/* File: core/uvp_ctrl.sv */
// Purpose: Host-side controller that reads, programs and identifies a UV EPROM.
// Assumes: Device data pins are sampled through two flops; voltages are qualifier outputs.
// Notes: One command at a time; busy is high from acceptance until done.
`timescale 1ns/10ps
module uvp_ctrl
  import uvp_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESETN_I,
  // User command port
  input wire logic CMD_VALID_I,
  input wire uvp_cmd_t CMD_I,
  input wire logic [ADDR_W-1:0] CMD_ADDR_I,
  input wire logic [DATA_W-1:0] CMD_DATA_I,
  output logic BUSY_O,
  output logic DONE_O,
  output uvp_res_t RESULT_O,
  output logic [DATA_W-1:0] RDATA_O,
  output logic [PULSE_W-1:0] PULSES_O,
  // Source data for the final compare pass
  output logic SRC_REQ_O,
  output logic [ADDR_W-1:0] SRC_ADDR_O,
  input wire logic [DATA_W-1:0] SRC_DATA_I,
  // Device pins
  output uvp_pins_t PINS_O,
  output logic [DATA_W-1:0] DATA_LINES_O,
  output logic DATA_LINES_OE_O,
  input wire logic [DATA_W-1:0] DATA_LINES_I
);

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_SETUP = 8'h02,
    S_PULSE = 8'h04,
    S_REC = 8'h08,
    S_VERIFY = 8'h10,
    S_SAMPLE = 8'h20,
    S_FINISH = 8'h40,
    S_SRC = 8'h80
  } uvp_state_t;

  uvp_state_t state_q;
  uvp_cmd_t cmd_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] sync1_q;
  logic [DATA_W-1:0] sync2_q;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic tmr_done;
  logic [CNT_W-1:0] access_cnt;

  function automatic logic odd_parity_ok(input logic [DATA_W-1:0] b);
    odd_parity_ok = ^b;
  endfunction

  // Sampling waits the access time plus the two synchroniser stages.
  assign access_cnt = CNT_W'(ACCESS_CYC + SYNC_STAGES);

  uvp_timer u_timer (
    .clk_i(SYS_CLK_I),
    .resetn_i(RESETN_I),
    .load_i(tmr_load),
    .count_i(tmr_count),
    .done_o(tmr_done)
  );

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= DATA_LINES_I;
      sync2_q <= sync1_q;
    end
  end

  always_comb
  begin
    tmr_load = 1'b0;
    tmr_count = access_cnt;
    case (state_q)
      S_SETUP:
      begin
        tmr_load = 1'b1;
        // The pulse ends one cycle after done, so one less keeps it at exactly the pulse length.
        tmr_count = (cmd_q == UVP_CMD_PROG) ? CNT_W'(PROG_PULSE_CYC - 1) : access_cnt;
      end
      S_REC:
      begin
        tmr_load = 1'b1;
      end
      default:
      begin
        tmr_load = 1'b0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      state_q <= S_IDLE;
      cmd_q <= UVP_CMD_READ;
      wdata_q <= ERASED_BYTE;
      PINS_O <= '{addr: ADDR_ZERO, chip_sel_n: 1'b1, out_en_n: 1'b1, prog_volt: 1'b0, id_volt: 1'b0,
                  prog_supply: 1'b0};
      DATA_LINES_O <= '0;
      DATA_LINES_OE_O <= 1'b0;
      BUSY_O <= 1'b0;
      DONE_O <= 1'b0;
      RESULT_O <= UVP_RES_OK;
      RDATA_O <= '0;
      PULSES_O <= '0;
      SRC_REQ_O <= 1'b0;
      SRC_ADDR_O <= ADDR_ZERO;
    end
    else
    begin
      DONE_O <= 1'b0;
      SRC_REQ_O <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          // Idle parks the device in standby with its outputs floating.
          PINS_O.chip_sel_n <= 1'b1;
          PINS_O.out_en_n <= 1'b1;
          PINS_O.prog_volt <= 1'b0;
          PINS_O.id_volt <= 1'b0;
          PINS_O.prog_supply <= 1'b0;
          DATA_LINES_OE_O <= 1'b0;
          if (CMD_VALID_I)
          begin
            cmd_q <= CMD_I;
            BUSY_O <= 1'b1;
            PULSES_O <= '0;
            RESULT_O <= UVP_RES_OK;
            wdata_q <= CMD_DATA_I;
            state_q <= S_SETUP;
            if (CMD_I == UVP_CMD_IDREAD)
            begin
              // Only bit zero may vary while the identifier voltage is on bit nine.
              PINS_O.addr <= {{(ADDR_W-1){1'b0}}, CMD_ADDR_I[0]};
              PINS_O.id_volt <= 1'b1;
            end
            else if (CMD_I == UVP_CMD_FINAL)
            begin
              // Final compare runs at normal supply from the first address.
              PINS_O.addr <= ADDR_ZERO;
              SRC_ADDR_O <= ADDR_ZERO;
            end
            else
            begin
              PINS_O.addr <= CMD_ADDR_I;
            end
            if (CMD_I == UVP_CMD_PROG)
            begin
              // Raised supply and program voltage, all data lines driven together.
              PINS_O.prog_supply <= 1'b1;
              PINS_O.prog_volt <= 1'b1;
              DATA_LINES_O <= CMD_DATA_I;
              DATA_LINES_OE_O <= 1'b1;
            end
          end
        end
        S_SETUP:
        begin
          // Address is stable first; chip select then opens the access or the pulse.
          PINS_O.chip_sel_n <= 1'b0;
          if (cmd_q == UVP_CMD_PROG)
          begin
            PULSES_O <= PULSES_O + PULSE_W'(1);
            state_q <= S_PULSE;
          end
          else
          begin
            PINS_O.out_en_n <= 1'b0;
            state_q <= S_SAMPLE;
          end
        end
        S_PULSE:
        begin
          if (tmr_done)
          begin
            // Chip select returns high to end the pulse; this also inhibits the rest of an array.
            PINS_O.chip_sel_n <= 1'b1;
            PINS_O.prog_volt <= 1'b0;
            DATA_LINES_OE_O <= 1'b0;
            state_q <= S_REC;
          end
        end
        S_REC:
        begin
          // Verify with both selects low; the device now drives the byte.
          PINS_O.chip_sel_n <= 1'b0;
          PINS_O.out_en_n <= 1'b0;
          state_q <= S_VERIFY;
        end
        S_VERIFY:
        begin
          if (tmr_done)
          begin
            PINS_O.out_en_n <= 1'b1;
            PINS_O.chip_sel_n <= 1'b1;
            RDATA_O <= sync2_q;
            if (sync2_q == wdata_q)
            begin
              RESULT_O <= UVP_RES_OK;
              state_q <= S_FINISH;
            end
            else if (PULSES_O >= MAX_PULSES_V)
            begin
              // Give up after the maximum number of pulses.
              RESULT_O <= UVP_RES_FAIL;
              state_q <= S_FINISH;
            end
            else
            begin
              // Another fixed pulse; bits can only fall from one to zero.
              PINS_O.prog_volt <= 1'b1;
              DATA_LINES_O <= wdata_q;
              DATA_LINES_OE_O <= 1'b1;
              state_q <= S_SETUP;
            end
          end
        end
        S_SAMPLE:
        begin
          if (tmr_done)
          begin
            RDATA_O <= sync2_q;
            PINS_O.out_en_n <= 1'b1;
            PINS_O.chip_sel_n <= 1'b1;
            if (cmd_q == UVP_CMD_IDREAD)
            begin
              // Identifier bytes must show odd parity on the top line.
              RESULT_O <= odd_parity_ok(sync2_q) ? UVP_RES_OK : UVP_RES_FAIL;
              state_q <= S_FINISH;
            end
            else if (cmd_q == UVP_CMD_FINAL)
            begin
              SRC_REQ_O <= 1'b1;
              state_q <= S_SRC;
            end
            else
            begin
              state_q <= S_FINISH;
            end
          end
        end
        S_SRC:
        begin
          // Source byte arrives one cycle after the request.
          if (!SRC_REQ_O)
          begin
            if (RDATA_O != SRC_DATA_I)
            begin
              RESULT_O <= UVP_RES_MISMATCH;
              state_q <= S_FINISH;
            end
            else if (PINS_O.addr == ADDR_LAST)
            begin
              state_q <= S_FINISH;
            end
            else
            begin
              PINS_O.addr <= PINS_O.addr + ADDR_W'(1);
              SRC_ADDR_O <= SRC_ADDR_O + ADDR_W'(1);
              state_q <= S_SETUP;
            end
          end
        end
        S_FINISH:
        begin
          PINS_O.prog_supply <= 1'b0;
          PINS_O.id_volt <= 1'b0;
          BUSY_O <= 1'b0;
          DONE_O <= 1'b1;
          state_q <= S_IDLE;
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: core/uvp_timer.sv */
// Purpose: Cycle countdown used for pulse widths and access waits.
// Assumes: Single clock domain; load takes priority over counting.
// Notes: done pulses for one cycle when the count reaches its end.
`timescale 1ns/10ps
module uvp_timer
  import uvp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control
  input wire logic load_i,
  input wire logic [CNT_W-1:0] count_i,
  // Status
  output logic done_o
);

  logic [CNT_W-1:0] cnt_q;
  logic run_q;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done_o <= 1'b0;
    end
    else if (load_i)
    begin
      cnt_q <= count_i;
      run_q <= 1'b1;
      done_o <= 1'b0;
    end
    else if (run_q)
    begin
      done_o <= (cnt_q == CNT_W'(1));
      run_q <= (cnt_q != CNT_W'(1));
      cnt_q <= cnt_q - CNT_W'(1);
    end
    else
    begin
      done_o <= 1'b0;
    end
  end

endmodule

/* File: inc/uvp_pkg.sv */
// Purpose: Shared constants and types for the UV EPROM programmer/reader controller.
// Assumes: 50 MHz system clock; device pins driven directly from flops.
// Notes: Functional notes below; voltage levels are modelled as qualifier outputs.
package uvp_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 16'hFFFF;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
  localparam int PARITY_BIT = 7;

  // Timing figures in their own units, converted at 50 MHz.
  localparam int CLK_MHZ = 50;
  localparam int PROG_PULSE_US = 100;
  localparam int PROG_PULSE_CYC = PROG_PULSE_US * CLK_MHZ;
  localparam int ACCESS_NS = 45;
  localparam int CLK_NS = 20;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_STAGES = 2;
  localparam int MAX_PULSES = 25;
  localparam int CNT_W = 16;
  localparam int PULSE_W = 5;
  localparam logic [PULSE_W-1:0] MAX_PULSES_V = 5'(MAX_PULSES);

  // Command codes presented on the user port.
  typedef enum logic [1:0] {
    UVP_CMD_READ = 2'h0,
    UVP_CMD_PROG = 2'h1,
    UVP_CMD_IDREAD = 2'h2,
    UVP_CMD_FINAL = 2'h3
  } uvp_cmd_t;

  // Result codes.
  typedef enum logic [1:0] {
    UVP_RES_OK = 2'h0,
    UVP_RES_FAIL = 2'h1,
    UVP_RES_MISMATCH = 2'h2
  } uvp_res_t;

  // Device pin bundle driven by the controller.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic chip_sel_n;
    logic out_en_n;
    logic prog_volt;
    logic id_volt;
    logic prog_supply;
  } uvp_pins_t;

endpackage

/* File: verification/tb_uvp_ctrl.sv */
// Purpose: Self-checking bench for the EPROM controller.
// Assumes: Device model on the far side; source data from a fixed table.
// Notes: Final compare stops early at a planted mismatch to keep the run short.
`timescale 1ns/10ps
module tb_uvp_ctrl;
  import uvp_pkg::*;
  // Arbitrary identifier values, both with odd parity.
  localparam logic [7:0] MK = 8'hB5;
  localparam logic [7:0] TY = 8'h8F;
  logic clk, rst_n, valid, bad, busy, done, src_req, c_oe, d_oe;
  uvp_cmd_t cmd;
  logic [15:0] addr, src_addr;
  logic [7:0] wdata, rdata, c_o, d_o, dq, dq_last, src, got_dat;
  logic [4:0] pulses, need, got_pul;
  uvp_res_t res, got_res;
  uvp_pins_t pins;
  int failures, num_checks;
  assign dq = c_oe ? c_o : (d_oe ? d_o : ~dq_last);
  assign src = (src_addr == 16'h0002) ? 8'h00 : ((src_addr == 16'h1234) ? 8'h5A : ERASED_BYTE);
  always @(posedge clk)
    if (c_oe || d_oe)
      dq_last <= dq;
  uvp_ctrl DUT (.SYS_CLK_I(clk), .RESETN_I(rst_n), .CMD_VALID_I(valid), .CMD_I(cmd), .CMD_ADDR_I(addr),
    .CMD_DATA_I(wdata), .BUSY_O(busy), .DONE_O(done), .RESULT_O(res), .RDATA_O(rdata), .PULSES_O(pulses),
    .SRC_REQ_O(src_req), .SRC_ADDR_O(src_addr), .SRC_DATA_I(src), .PINS_O(pins), .DATA_LINES_O(c_o),
    .DATA_LINES_OE_O(c_oe), .DATA_LINES_I(dq));
  uvp_eprom_model #(.MAKER_CODE(MK), .TYPE_CODE(TY)) u_dev (.pins_i(pins), .dq_i(dq), .need_i(need),
    .bad_id_i(bad), .dq_o(d_o), .dq_oe_o(d_oe));
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_res(input uvp_res_t exp);
    num_checks++;
    if (got_res !== exp)
    begin
      failures++;
      $display("[FAIL] %0t result %0d expected %0d", $time, got_res, exp);
    end
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run_cmd(input uvp_cmd_t c, input logic [15:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    #2;
    valid = 1'b1;
    cmd = c;
    addr = a;
    wdata = d;
    @(posedge clk);
    #2;
    valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20000)
    begin
      @(posedge clk);
      #2;
      n++;
    end
    if (n >= 20000)
    begin
      failures++;
      $display("[FAIL] %0t no completion", $time);
    end
    got_res = res;
    got_dat = rdata;
    got_pul = pulses;
  endtask
  task automatic t_read_erased;
    need = 5'h00;
    run_cmd(UVP_CMD_READ, 16'h0100, 8'h00);
    chk_res(UVP_RES_OK);
    chk_val(got_dat, ERASED_BYTE);
  endtask
  task automatic t_prog_retry;
    need = 5'h03;
    run_cmd(UVP_CMD_PROG, 16'h1234, 8'h5A);
    chk_res(UVP_RES_OK);
    chk_val({3'h0, got_pul}, 8'h03);
    run_cmd(UVP_CMD_READ, 16'h1234, 8'h00);
    chk_val(got_dat, 8'h5A);
  endtask
  task automatic t_idread;
    bad = 1'b0;
    run_cmd(UVP_CMD_IDREAD, 16'h0000, 8'h00);
    chk_val(got_dat, MK);
    chk_res(UVP_RES_OK);
    run_cmd(UVP_CMD_IDREAD, 16'h0001, 8'h00);
    chk_val(got_dat, TY);
    bad = 1'b1;
    run_cmd(UVP_CMD_IDREAD, 16'h0001, 8'h00);
    chk_res(UVP_RES_FAIL);
    bad = 1'b0;
  endtask
  task automatic t_final;
    run_cmd(UVP_CMD_FINAL, 16'h0000, 8'h00);
    chk_res(UVP_RES_MISMATCH);
    chk_val(src_addr[7:0], 8'h02);
    chk_val(got_dat, ERASED_BYTE);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial
  begin
    rst_n = 1'b0;
    valid = 1'b0;
    cmd = UVP_CMD_READ;
    addr = 16'h0000;
    wdata = 8'h00;
    need = 5'h00;
    bad = 1'b0;
    dq_last = 8'h00;
    failures = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    #2;
    rst_n = 1'b1;
    t_read_erased();
    t_prog_retry();
    t_idread();
    t_final();
    tally_and_finish();
  end
endmodule

/* File: verification/uvp_ctrl_chk.sv */
// Purpose: Pin and handshake checks for the EPROM controller.
// Assumes: Bound to uvp_ctrl; one clock domain.
// Notes: Program pulse width is measured by a helper counter.
`timescale 1ns/10ps
module uvp_ctrl_chk
  import uvp_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RESETN_I,
  input wire logic CMD_VALID_I,
  input wire uvp_cmd_t CMD_I,
  input wire logic BUSY_O,
  input wire logic DONE_O,
  input wire logic [PULSE_W-1:0] PULSES_O,
  input wire uvp_pins_t PINS_O,
  input wire logic DATA_LINES_OE_O
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  logic [CNT_W-1:0] pw_q;
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      pw_q <= '0;
    else if (!PINS_O.chip_sel_n && PINS_O.prog_volt)
      pw_q <= pw_q + 16'h0001;
    else
      pw_q <= '0;
  end
  sequence s_read_acc;
    !BUSY_O && CMD_VALID_I && (CMD_I == UVP_CMD_READ);
  endsequence
  sequence s_strobe;
    $fell(PINS_O.out_en_n) && !PINS_O.prog_volt;
  endsequence
  a_prog_supply_up: assert property (PINS_O.prog_volt |-> PINS_O.prog_supply)
    else $error("program voltage without raised supply");
  a_drive_only_prog: assert property (DATA_LINES_OE_O |-> PINS_O.prog_volt)
    else $error("data lines driven outside programming");
  a_id_lines_low: assert property (PINS_O.id_volt |-> PINS_O.addr[15:1] == 15'h0000)
    else $error("address lines not low in identifier readout");
  a_id_no_prog: assert property (PINS_O.id_volt |-> !PINS_O.prog_volt)
    else $error("identifier voltage with program voltage");
  a_pulse_width: assert property ($rose(PINS_O.chip_sel_n) && $past(PINS_O.prog_volt) |-> pw_q == PROG_PULSE_CYC)
    else $error("program pulse width wrong");
  a_pulse_limit: assert property (PULSES_O <= MAX_PULSES_V)
    else $error("pulse count above limit");
  a_pulse_ends_sel: assert property ($fell(PINS_O.prog_volt) |-> PINS_O.chip_sel_n)
    else $error("program voltage removed with chip select low");
  a_read_done: assert property (s_read_acc |-> ##[3:12] DONE_O)
    else $error("read did not complete in time");
  a_strobe_hold: assert property (s_strobe |-> !PINS_O.chip_sel_n ##1 (!PINS_O.out_en_n && !PINS_O.chip_sel_n) [*2])
    else $error("read strobe released before access time");
  a_idle_standby: assert property (!BUSY_O |-> PINS_O.chip_sel_n && PINS_O.out_en_n)
    else $error("device selected while controller idle");
endmodule

bind uvp_ctrl uvp_ctrl_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .CMD_VALID_I(CMD_VALID_I),
  .CMD_I(CMD_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .PULSES_O(PULSES_O), .PINS_O(PINS_O),
  .DATA_LINES_OE_O(DATA_LINES_OE_O));

/* File: verification/uvp_eprom_model.sv */
// Purpose: Behavioural model of the UV EPROM at the controller's pins.
// Assumes: Voltage levels arrive as qualifier inputs.
// Notes: need_i sets how many pulses a byte takes; bad_id_i spoils identifier parity.
`timescale 1ns/10ps
module uvp_eprom_model
  import uvp_pkg::*;
#(
  // Both identifier defaults are arbitrary values with odd parity.
  parameter logic [DATA_W-1:0] MAKER_CODE = 8'hB5,
  parameter logic [DATA_W-1:0] TYPE_CODE = 8'h8F
)
(
  input wire uvp_pins_t pins_i,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic [PULSE_W-1:0] need_i,
  input wire logic bad_id_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o
);
  logic [DATA_W-1:0] mem [0:65535];
  logic [PULSE_W-1:0] n_q;
  logic [DATA_W-1:0] val;
  logic [DATA_W-1:0] id_b;
  wire logic cs_n = pins_i.chip_sel_n;
  wire logic vpp = pins_i.prog_volt;
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = ERASED_BYTE;
    n_q = '0;
  end
  always @(posedge pins_i.prog_supply)
    n_q = '0;
  always @(negedge cs_n)
    if (vpp && pins_i.prog_supply)
    begin
      n_q = n_q + 5'h01;
      if (n_q >= need_i)
        mem[pins_i.addr] = mem[pins_i.addr] & dq_i;
    end
  assign id_b = pins_i.addr[0] ? TYPE_CODE : MAKER_CODE;
  assign val = pins_i.id_volt ? (id_b ^ {bad_id_i, 7'h00}) : mem[pins_i.addr];
  assign dq_oe_o = !cs_n && !pins_i.out_en_n && !vpp;
  // Until the access time has passed the lines show the inverse, so an early sample fails.
  always @(val or dq_oe_o)
  begin
    dq_o = ~val;
    dq_o <= #(ACCESS_NS) val;
  end
endmodule
